// File: logic/sdsc_ctrl.sv
// Purpose: Stall detection settings, motion flags, bus error status, node
//          address and frame checksum check.
// Assumes: All inputs synchronous to clk; commands are one-cycle pulses.
// Notes: Analog comparison is done in digital on a scaled back-emf code.
`timescale 1ns/100ps
`include "sdsc_map.svh"

module sdsc_ctrl #(
    parameter int BEMF_W = 8,
    parameter int MAX_BYTES = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire sdsc_pkg::sdsc_params_t fused_params,
    input wire logic [3:0] fused_address_bits,
    input wire logic [2:0] strap_address_pins,
    input wire logic write_block_params,
    input wire sdsc_pkg::sdsc_params_t write_data,
    input wire logic bemf_observe_command,
    input wire logic full_status_query,
    input wire logic short_status_query,
    input wire sdsc_pkg::sdsc_motion_t motion,
    input wire sdsc_pkg::sdsc_bus_faults_t bus_faults,
    input wire logic switch_input,
    input wire logic frame_check,
    input wire logic [3:0] frame_bytes,
    input wire logic [MAX_BYTES*8-1:0] frame_data,
    input wire logic [7:0] frame_checksum,
    output sdsc_pkg::sdsc_params_t params,
    output sdsc_pkg::sdsc_flags_t resp_flags,
    output logic [7:0] bus_error_status,
    output logic resp_valid,
    output logic [6:0] node_address,
    output logic sample_take,
    output logic stall_armed,
    output logic halt,
    output logic position_copy,
    output logic observe_mode,
    output logic switch_state,
    output logic checksum_ok
);
    import sdsc_pkg::*;

    // Comparison and checksum paths are written for these sizes only.
    if (BEMF_W != 8 || MAX_BYTES != 8) begin : g_bad_size
        $error("sdsc_ctrl supports BEMF_W 8 and MAX_BYTES 8 only");
    end

    // ------------------------------------------------------------
    // Sample delay table
    // ------------------------------------------------------------
    function automatic logic [13:0] delay_cycles(input logic [2:0] code);
        logic [13:0] c;
        c = 14'h0000;
        case (code)
            3'h0: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US0));
            3'h1: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US1));
            3'h2: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US2));
            3'h3: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US3));
            3'h4: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US4));
            3'h5: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US5));
            3'h6: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US6));
            default: c = 14'(`SDSC_US2CYC(`SDSC_DLY_US7));
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // Classic checksum
    // ------------------------------------------------------------
    // Only 2, 4 and 8 byte frames are legal; any other count fails.
    function automatic logic [7:0] classic_sum(
        input logic [MAX_BYTES*8-1:0] data,
        input logic [3:0] n
    );
        logic [8:0] acc;
        acc = 9'h000;
        for (int i = 0; i < MAX_BYTES; i++) begin
            if (4'(i) < n) begin
                acc = {1'b0, acc[7:0]} + {1'b0, data[i*8 +: 8]};
                acc = {1'b0, acc[7:0]} + {8'h00, acc[8]};
            end
        end
        return ~acc[7:0];
    endfunction

    sdsc_state_t s_r;
    sdsc_state_t s_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic detect_en;
        logic evaluate;
        logic dip_hit;
        logic surge_hit;
        logic level_hit;
        logic stall_hit;
        logic [8:0] abs_lvl;
        logic [8:0] del_lvl;
        logic [8:0] avg;
        logic [8:0] lvl;
        logic [7:0] err_set;
        sdsc_flags_t fl;
        detect_en = 1'b0;
        evaluate = 1'b0;
        dip_hit = 1'b0;
        surge_hit = 1'b0;
        level_hit = 1'b0;
        stall_hit = 1'b0;
        abs_lvl = 9'h000;
        del_lvl = 9'h000;
        avg = 9'h000;
        lvl = 9'h000;
        err_set = 8'h00;
        fl = s_r.flags;
        s_nxt = s_r;
        s_nxt.sample_take = 1'b0;
        s_nxt.halt = 1'b0;
        s_nxt.position_copy = 1'b0;
        s_nxt.resp_valid = 1'b0;

        // --------------------------------------------------------
        // Working parameters and node address
        // --------------------------------------------------------
        // Fused limits enter working memory once, right after reset.
        if (!s_r.loaded) begin
            s_nxt.params = fused_params;
            s_nxt.loaded = 1'b1;
            s_nxt.node_address = {strap_address_pins[0],
                strap_address_pins[1], strap_address_pins[2],
                fused_address_bits};
        end else if (write_block_params) begin
            s_nxt.params = write_data;
        end

        // --------------------------------------------------------
        // Observation mode
        // --------------------------------------------------------
        // Observation mode is sticky; only the reset ends it.
        if (bemf_observe_command) begin
            s_nxt.observe_mode = 1'b1;
        end
        if (!s_r.observe_mode) begin
            s_nxt.switch_state = switch_input;
        end

        detect_en = (s_r.params.absolute_limit != 4'h0) ||
            (s_r.params.delta_limit != 4'h0);

        // --------------------------------------------------------
        // Activation delay
        // --------------------------------------------------------
        // Activation delay counts full steps after the ramp.
        case (s_r.arm)
            SDSC_IDLE: begin
                if (detect_en && motion.ramp_done) begin
                    s_nxt.step_cnt = 3'h0;
                    s_nxt.arm = (s_r.params.arm_step_delay == 3'h0) ?
                        SDSC_ARMED : SDSC_ARMING;
                end
            end
            SDSC_ARMING: begin
                if (!detect_en || !motion.ramp_done) begin
                    s_nxt.arm = SDSC_IDLE;
                end else if (motion.full_step) begin
                    s_nxt.step_cnt = s_r.step_cnt + 3'h1;
                    if (s_r.step_cnt + 3'h1 ==
                            s_r.params.arm_step_delay) begin
                        s_nxt.arm = SDSC_ARMED;
                    end
                end
            end
            SDSC_ARMED: begin
                if (!detect_en || !motion.ramp_done) begin
                    s_nxt.arm = SDSC_IDLE;
                end
            end
            default: s_nxt.arm = SDSC_IDLE;
        endcase
        // A registered copy keeps the armed output free of decode glitches.
        s_nxt.armed = (s_nxt.arm == SDSC_ARMED);

        // --------------------------------------------------------
        // Sample delay timer
        // --------------------------------------------------------
        // Sample timer restarts on every zero crossing outside the take cycle.
        case (s_r.samp)
            SDSC_SAMP_IDLE: begin
                if (motion.zero_cross) begin
                    s_nxt.delay_cnt =
                        delay_cycles(s_r.params.sample_delay_select);
                    s_nxt.samp = SDSC_SAMP_WAIT;
                end
            end
            SDSC_SAMP_WAIT: begin
                if (motion.zero_cross) begin
                    s_nxt.delay_cnt =
                        delay_cycles(s_r.params.sample_delay_select);
                end else if (s_r.delay_cnt <= 14'h0001) begin
                    s_nxt.samp = SDSC_SAMP_TAKE;
                end else begin
                    s_nxt.delay_cnt = s_r.delay_cnt - 14'h0001;
                end
            end
            SDSC_SAMP_TAKE: begin
                s_nxt.sample_take = 1'b1;
                s_nxt.samp = SDSC_SAMP_IDLE;
            end
            default: s_nxt.samp = SDSC_SAMP_IDLE;
        endcase

        // --------------------------------------------------------
        // Stall comparison
        // --------------------------------------------------------
        // Levels in units of 0.25 V on the back-emf code scale.
        abs_lvl = {4'h0, s_r.params.absolute_limit, 1'b0};
        del_lvl = {5'h00, s_r.params.delta_limit};
        avg = {1'b0, motion.bemf_average};
        lvl = {1'b0, motion.bemf_level};
        evaluate = (s_r.arm == SDSC_ARMED) && motion.sample_ready &&
            motion.at_max_velocity &&
            (!motion.full_duty ||
             s_r.params.full_duty_detect_enable);
        if (evaluate) begin
            level_hit = (s_r.params.absolute_limit != 4'h0) &&
                (lvl < abs_lvl);
            dip_hit = (s_r.params.delta_limit != 4'h0) &&
                (lvl + del_lvl < avg);
            surge_hit = (s_r.params.delta_limit != 4'h0) &&
                (lvl > avg + del_lvl);
        end
        stall_hit = level_hit || dip_hit || surge_hit;

        // --------------------------------------------------------
        // Motion flags
        // --------------------------------------------------------
        // Capture first, then clear; a new hit in the same cycle stays.
        if (full_status_query || short_status_query) begin
            s_nxt.resp_flags = s_r.flags;
            s_nxt.resp_error = s_r.error_status;
            s_nxt.resp_valid = 1'b1;
        end
        if (full_status_query) begin
            fl = '0;
        end else if (short_status_query) begin
            fl.missed_step = 1'b0;
        end
        fl.level_block = fl.level_block | level_hit;
        fl.dip_block = fl.dip_block | dip_hit;
        fl.surge_block = fl.surge_block | surge_hit;
        fl.motion_block = fl.level_block | fl.dip_block |
            fl.surge_block;
        if (stall_hit && motion.positioning) begin
            fl.missed_step = 1'b1;
            s_nxt.halt = 1'b1;
            s_nxt.position_copy = 1'b1;
        end
        s_nxt.flags = fl;

        // --------------------------------------------------------
        // Bus error status
        // --------------------------------------------------------
        // Bits 7 to 4 are never set, so they always read as zero.
        err_set[`SDSC_ERR_DATA] = bus_faults.checksum_fault |
            bus_faults.stop_bit_fault | bus_faults.length_fault |
            (frame_check && !checksum_ok_now());
        err_set[`SDSC_ERR_HEADER] = bus_faults.parity_fault |
            bus_faults.sync_fault;
        err_set[`SDSC_ERR_TIMEOUT] = bus_faults.frame_overrun;
        err_set[`SDSC_ERR_BIT] = bus_faults.readback_fault;
        s_nxt.error_status = (full_status_query ? `SDSC_ERR_RESET :
            s_r.error_status) | err_set;
        if (frame_check) begin
            s_nxt.checksum_ok = checksum_ok_now();
        end
    end

    function automatic logic checksum_ok_now();
        logic ok;
        ok = ((frame_bytes == 4'h2) || (frame_bytes == 4'h4) ||
            (frame_bytes == 4'h8)) &&
            (classic_sum(frame_data, frame_bytes) == frame_checksum);
        return ok;
    endfunction

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a field of the state register.
    assign params = s_r.params;
    assign resp_flags = s_r.resp_flags;
    assign bus_error_status = s_r.error_status;
    assign resp_valid = s_r.resp_valid;
    assign node_address = s_r.node_address;
    assign sample_take = s_r.sample_take;
    assign stall_armed = s_r.armed;
    assign halt = s_r.halt;
    assign position_copy = s_r.position_copy;
    assign observe_mode = s_r.observe_mode;
    assign switch_state = s_r.switch_state;
    assign checksum_ok = s_r.checksum_ok;

endmodule

// File: logic/sdsc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Clock at 20 MHz.
// Notes: Definitions only.
`ifndef SDSC_MAP_SVH
`define SDSC_MAP_SVH

`define SDSC_CLK_KHZ 20000
// Error status bit positions.
`define SDSC_ERR_TIMEOUT 3
`define SDSC_ERR_DATA 2
`define SDSC_ERR_HEADER 1
`define SDSC_ERR_BIT 0
`define SDSC_ERR_RESET 8'h00
// Sample delays in microseconds, code 0 to 7.
`define SDSC_DLY_US0 87
`define SDSC_DLY_US1 130
`define SDSC_DLY_US2 174
`define SDSC_DLY_US3 217
`define SDSC_DLY_US4 261
`define SDSC_DLY_US5 304
`define SDSC_DLY_US6 348
`define SDSC_DLY_US7 391
// Least time rounds up to whole cycles.
`define SDSC_US2CYC(us) (((us) * `SDSC_CLK_KHZ + 999) / 1000)
`define SDSC_MAX_STEP_DELAY 7

`endif

// File: logic/sdsc_pkg.sv
// Purpose: Types for the stall detection and status block.
// Assumes: Nothing beyond the map header.
// Notes: Types only.
package sdsc_pkg;

    typedef struct packed {
        logic [3:0] absolute_limit;
        logic [3:0] delta_limit;
        logic [2:0] sample_delay_select;
        logic [2:0] arm_step_delay;
        logic full_duty_detect_enable;
    } sdsc_params_t;

    typedef struct packed {
        logic missed_step;
        logic motion_block;
        logic level_block;
        logic dip_block;
        logic surge_block;
    } sdsc_flags_t;

    typedef struct packed {
        logic checksum_fault;
        logic stop_bit_fault;
        logic length_fault;
        logic parity_fault;
        logic sync_fault;
        logic frame_overrun;
        logic readback_fault;
    } sdsc_bus_faults_t;

    typedef struct packed {
        logic zero_cross;
        logic sample_ready;
        logic [7:0] bemf_level;
        logic [7:0] bemf_average;
        logic at_max_velocity;
        logic ramp_done;
        logic full_step;
        logic full_duty;
        logic positioning;
    } sdsc_motion_t;

    typedef enum logic [1:0] {
        SDSC_IDLE,
        SDSC_ARMING,
        SDSC_ARMED
    } sdsc_arm_t;

    typedef enum logic [1:0] {
        SDSC_SAMP_IDLE,
        SDSC_SAMP_WAIT,
        SDSC_SAMP_TAKE
    } sdsc_samp_t;

    typedef struct packed {
        sdsc_params_t params;
        sdsc_flags_t flags;
        logic [7:0] error_status;
        sdsc_arm_t arm;
        logic armed;
        logic [2:0] step_cnt;
        sdsc_samp_t samp;
        logic [13:0] delay_cnt;
        logic sample_take;
        logic observe_mode;
        logic loaded;
        logic [6:0] node_address;
        logic switch_state;
        logic halt;
        logic position_copy;
        sdsc_flags_t resp_flags;
        logic [7:0] resp_error;
        logic resp_valid;
        logic checksum_ok;
    } sdsc_state_t;

endpackage

// File: verification/sdsc_ctrl_asserts.sv
// Purpose: Concurrent checks on the stall and status block ports.
// Assumes: One clock domain; bound to every sdsc_ctrl.
// Notes: Fault inputs are one-cycle pulses, so each check is one cycle on.
`timescale 1ns/100ps
module sdsc_ctrl_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic write_block_params,
    input wire sdsc_pkg::sdsc_params_t write_data,
    input wire logic full_status_query,
    input wire sdsc_pkg::sdsc_bus_faults_t bus_faults,
    input wire logic frame_check,
    input wire sdsc_pkg::sdsc_params_t params,
    input wire logic [7:0] bus_error_status,
    input wire logic resp_valid,
    input wire logic halt,
    input wire logic observe_mode,
    input wire logic switch_state
);
    import sdsc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_resp;
        full_status_query |=> resp_valid;
    endproperty
    a_resp: assert property (p_resp) else $error("no response");
    // A fault in the query cycle must survive, so only quiet cycles count.
    property p_eclr;
        full_status_query && bus_faults == '0 && !frame_check
            |=> bus_error_status == 8'h00;
    endproperty
    a_eclr: assert property (p_eclr) else $error("not cleared");
    property p_data;
        bus_faults.checksum_fault || bus_faults.stop_bit_fault ||
            bus_faults.length_fault |=> bus_error_status[2];
    endproperty
    a_data: assert property (p_data) else $error("data flag");
    property p_hdr;
        bus_faults.parity_fault || bus_faults.sync_fault |=> bus_error_status[1];
    endproperty
    a_hdr: assert property (p_hdr) else $error("header flag");
    property p_tmo;
        bus_faults.frame_overrun |=> bus_error_status[3];
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout flag");
    property p_bit;
        bus_faults.readback_fault |=> bus_error_status[0];
    endproperty
    a_bit: assert property (p_bit) else $error("bit flag");
    property p_wr;
        write_block_params && !$past(sys_rst) |=> params == $past(write_data);
    endproperty
    a_wr: assert property (p_wr) else $error("params not stored");
    property p_obs;
        observe_mode |=> observe_mode && $stable(switch_state);
    endproperty
    a_obs: assert property (p_obs) else $error("observe");
    c_halt: cover property (halt);
    c_obs: cover property ($rose(observe_mode));
    c_clr: cover property (full_status_query && bus_error_status != 8'h00);
endmodule

bind sdsc_ctrl sdsc_ctrl_asserts u_chk (
    .clk, .sys_rst, .write_block_params, .write_data, .full_status_query,
    .bus_faults, .frame_check, .params, .bus_error_status, .resp_valid,
    .halt, .observe_mode, .switch_state
);

// File: verification/sdsc_master.sv
// Purpose: Bus master model issuing status and parameter commands.
// Assumes: Commands launch on the falling edge of clk.
// Notes: Released write data is inverted so it never reads as held.
`timescale 1ns/100ps
module sdsc_master (
    input wire logic clk,
    output logic full_status_query,
    output logic short_status_query,
    output logic write_block_params,
    output logic bemf_observe_command,
    output sdsc_pkg::sdsc_params_t write_data
);
    import sdsc_pkg::*;
    initial begin
        {full_status_query, short_status_query} = 2'b00;
        {write_block_params, bemf_observe_command} = 2'b00;
        write_data = '0;
    end
    // Strobes stand one clock; op 0 full, 1 short, 2 write, 3 observe.
    task send(input logic [1:0] op, input sdsc_params_t d);
        @(negedge clk);
        write_data = d;
        full_status_query = (op == 2'd0);
        short_status_query = (op == 2'd1);
        write_block_params = (op == 2'd2);
        bemf_observe_command = (op == 2'd3);
        @(negedge clk);
        {full_status_query, short_status_query} = 2'b00;
        {write_block_params, bemf_observe_command} = 2'b00;
        write_data = ~d;
    endtask
endmodule

// File: verification/tb_stall_detect_status_ctrl.sv
// Purpose: Self-checking bench for the stall detection and status block.
// Assumes: 20 MHz clock; inputs change on the falling edge.
// Notes: Commands reach the block through the bus master model.
`timescale 1ns/100ps
module tb_stall_detect_status_ctrl;
    import sdsc_pkg::*;
    localparam logic [22:0] ZC = 23'h400000;
    localparam logic [22:0] SR = 23'h200000;
    localparam logic [22:0] FS = 23'h000004;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    sdsc_params_t fused_params, write_data, params, p;
    sdsc_flags_t resp_flags;
    sdsc_motion_t motion;
    sdsc_bus_faults_t bus_faults;
    logic [3:0] fused_address_bits, frame_bytes;
    logic [2:0] strap_address_pins;
    logic [63:0] frame_data;
    logic [7:0] frame_checksum, bus_error_status;
    logic [6:0] node_address;
    logic write_block_params, bemf_observe_command, full_status_query;
    logic short_status_query, switch_input, frame_check, resp_valid;
    logic sample_take, stall_armed, halt, position_copy, observe_mode;
    logic switch_state, checksum_ok;
    int mismatches = 0, checked = 0, cycles = 0, halts = 0, copies = 0;
    sdsc_ctrl dut (
        .clk, .sys_rst, .fused_params, .fused_address_bits,
        .strap_address_pins, .write_block_params, .write_data,
        .bemf_observe_command, .full_status_query, .short_status_query,
        .motion, .bus_faults, .switch_input, .frame_check, .frame_bytes,
        .frame_data, .frame_checksum, .params, .resp_flags,
        .bus_error_status, .resp_valid, .node_address, .sample_take,
        .stall_armed, .halt, .position_copy, .observe_mode, .switch_state,
        .checksum_ok
    );
    sdsc_master m (
        .clk, .full_status_query, .short_status_query,
        .write_block_params, .bemf_observe_command, .write_data
    );
    always #25 clk = ~clk;
    // The whole run needs about 1900 cycles; the ceiling leaves margin.
    always @(posedge clk) begin
        if (halt === 1'b1) halts <= halts + 1;
        if (position_copy === 1'b1) copies <= copies + 1;
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            stop_test;
        end
    end
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task pulse(input logic [22:0] mask);
        motion = motion | mask;
        tick(1);
        motion = motion & ~mask;
        tick(2);
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic [7:0] csum(input logic [63:0] d, input int n);
        logic [8:0] s;
        s = 9'h000;
        for (int i = 0; i < n; i++) begin
            s = s[7:0] + d[i*8 +: 8];
            s = s[7:0] + s[8];
        end
        return ~s[7:0];
    endfunction
    task t_stall;
        logic [4:0] ex [4] = '{5'h1c, 5'h0c, 5'h0c, 5'h00};
        p = '{4'h0, 4'h0, 3'h0, 3'h0, 1'b0};
        m.send(2'd2, p);
        motion.ramp_done = 1'b1;
        tick(2);
        pulse(SR);
        chk(16'(halts), 16'h0000);
        chk(stall_armed, 1'b0);
        motion.ramp_done = 1'b0;
        p = '{4'h4, 4'h0, 3'h0, 3'h2, 1'b0};
        m.send(2'd2, p);
        chk(params, p);
        motion.ramp_done = 1'b1;
        tick(1);
        pulse(FS);
        chk(stall_armed, 1'b0);
        pulse(FS);
        chk(stall_armed, 1'b1);
        motion.full_duty = 1'b1;
        pulse(SR);
        motion.full_duty = 1'b0;
        motion.at_max_velocity = 1'b0;
        pulse(SR);
        chk(16'(halts), 16'h0000);
        motion.at_max_velocity = 1'b1;
        pulse(SR);
        chk(16'(halts), 16'h0001);
        chk(16'(copies), 16'h0001);
        foreach (ex[i]) begin
            m.send(i < 2 ? 2'd1 : 2'd0, p);
            chk(resp_flags, ex[i]);
        end
        $display("stall test done");
    endtask
    task t_level;
        logic [15:0] tab [5] = '{16'h4045, 16'h4145, 16'h4a45, 16'h0808,
            16'h0707};
        logic [4:0] ex [5] = '{5'h1a, 5'h00, 5'h19, 5'h00, 5'h1c};
        motion.ramp_done = 1'b0;
        m.send(2'd2, sdsc_params_t'{4'h4, 4'h4, 3'h0, 3'h0, 1'b0});
        motion.ramp_done = 1'b1;
        tick(2);
        foreach (tab[i]) begin
            {motion.bemf_level, motion.bemf_average} = tab[i];
            pulse(SR);
            m.send(2'd0, '0);
            chk(resp_flags, ex[i]);
        end
        $display("level test done");
    endtask
    task t_err;
        logic [7:0] eb [7] = '{8'h04, 8'h04, 8'h04, 8'h02, 8'h02, 8'h08,
            8'h01};
        foreach (eb[i]) begin
            bus_faults = 7'h40 >> i;
            tick(1);
            bus_faults = '0;
            tick(1);
            chk(bus_error_status, eb[i]);
            m.send(2'd1, '0);
            chk(bus_error_status, eb[i]);
            m.send(2'd0, '0);
            chk(bus_error_status, 8'h00);
        end
        $display("error test done");
    endtask
    task t_csum;
        int nb [5] = '{2, 4, 8, 3, 2};
        frame_data = 64'h0123_4567_89ab_cdef;
        foreach (nb[i]) begin
            frame_bytes = 4'(nb[i]);
            frame_checksum = csum(frame_data, nb[i]) ^ {7'h00, i == 4};
            frame_check = 1'b1;
            tick(1);
            frame_check = 1'b0;
            tick(1);
            chk(checksum_ok, i < 3);
        end
        chk(bus_error_status, 8'h04);
        m.send(2'd0, '0);
        $display("checksum test done");
    endtask
    // Delay code 0 is 87 us, 1740 cycles; a few cycles of pipeline allowed.
    task t_delay;
        int n;
        n = 0;
        motion = motion | ZC;
        tick(1);
        motion = motion & ~ZC;
        while (sample_take !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        chk(n >= 1738 && n <= 1746, 1'b1);
        $display("delay test done");
    endtask
    task t_observe;
        switch_input = 1'b1;
        tick(3);
        chk(switch_state, 1'b1);
        m.send(2'd3, '0);
        switch_input = 1'b0;
        tick(3);
        chk({observe_mode, switch_state}, 2'b11);
        $display("observe test done");
    endtask
    initial begin
        fused_params = '{4'h3, 4'h5, 3'h2, 3'h1, 1'b1};
        fused_address_bits = 4'ha;
        strap_address_pins = 3'b011;
        motion = '0;
        motion.bemf_level = 8'h03;
        motion.bemf_average = 8'h40;
        motion.at_max_velocity = 1'b1;
        motion.positioning = 1'b1;
        bus_faults = '0;
        {switch_input, frame_check, frame_bytes} = 6'h00;
        {frame_data, frame_checksum} = '0;
        repeat (8) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        tick(2);
        chk(params, fused_params);
        chk(node_address, 7'h6a);
        t_stall;
        t_level;
        t_err;
        t_csum;
        t_delay;
        t_observe;
        stop_test;
    end
endmodule
